/* File: verilog/motor_setup_pkg.sv */
/*
 * shared constants for the motor serial setup port: word size, setup field
 * positions, reset values and the extended-setup field layout.
 * assumes nothing beyond a systemverilog compiler.
 */
package motor_setup_pkg;

  localparam int unsigned WORD_W = 16;

  // setup register field positions
  localparam int unsigned CFG_LSB      = 0;
  localparam int unsigned BLANK_AB_LSB = 3;
  localparam int unsigned BLANK_CD_LSB = 5;
  localparam int unsigned CONV_A_BIT   = 7;
  localparam int unsigned CONV_B_BIT   = 8;
  localparam int unsigned CONV_C_BIT   = 9;
  localparam int unsigned GAIN_AB_BIT  = 10;
  localparam int unsigned GAIN_CD_BIT  = 11;
  localparam int unsigned CONV_OSC_LSB = 12;
  localparam int unsigned MOT_OSC_LSB  = 14;

  // extended setup field positions
  localparam int unsigned MON_SEL_LSB   = 0;
  localparam int unsigned IGNORE_LSB    = 4;
  localparam int unsigned ORT_SUPPR_BIT = 8;

  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [15:0] EXT_RESET   = 16'h0000;
  localparam logic [15:0] PARAM_RESET = 16'h0000;

  // monitor selector codes for identifier readout
  localparam logic [3:0] MON_DEV_ID0 = 4'hC;
  localparam logic [3:0] MON_DEV_ID1 = 4'hD;
  localparam logic [3:0] MON_DEV_ID2 = 4'hE;
  localparam logic [3:0] MON_VEND_ID = 4'hF;

  // fixed stepper blanking, in eighths of the chopping period
  localparam logic [3:0] STEP_BLANK_EIGHTHS = 4'h5;

  typedef enum logic [2:0] {
    CFG_DUAL_STEPPER,
    CFG_STEPPER_LARGE_DC,
    CFG_STEPPER_TWO_SMALL_DC,
    CFG_LARGE_DC_TWO_SMALL_DC,
    CFG_TWO_LARGE_DC,
    CFG_FOUR_SMALL_DC,
    CFG_LARGE_STEPPER,
    CFG_ULTRA_LARGE_DC
  } bridge_cfg_e;

endpackage : motor_setup_pkg

/* File: verilog/serial_port_rx.sv */
/*
 * one three-wire serial receiver: synchronises clock, data and strobe,
 * shifts data on the falling clock edge, pulses on the strobe rising edge.
 * assumes the pins are asynchronous to ref_clk and much slower than it.
 */
`timescale 1ns/1ps
module serial_port_rx #(
  parameter int unsigned W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         ser_clk,
  input  wire logic         ser_data,
  input  wire logic         strobe,
  output logic [W-1:0]      word_r,
  output logic              select_r,
  output logic              latch_r
);
  logic [1:0] clk_sy_r;
  logic [1:0] dat_sy_r;
  logic [1:0] stb_sy_r;
  logic       clk_prev_r;
  logic       stb_prev_r;
  logic [W-1:0] shift_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sy_r   <= 2'h0;
      dat_sy_r   <= 2'h0;
      stb_sy_r   <= 2'h0;
      clk_prev_r <= 1'b0;
      stb_prev_r <= 1'b0;
    end else if (clk_en) begin
      clk_sy_r   <= {clk_sy_r[0], ser_clk};
      dat_sy_r   <= {dat_sy_r[0], ser_data};
      stb_sy_r   <= {stb_sy_r[0], strobe};
      clk_prev_r <= clk_sy_r[1];
      stb_prev_r <= stb_sy_r[1];
    end
  end

  // R1: shift on falling edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (clk_en && clk_prev_r && !clk_sy_r[1]) begin
      shift_r <= {shift_r[W-2:0], dat_sy_r[1]};
    end
  end

  // R3: strobe rising edge only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_r   <= '0;
      select_r <= 1'b0;
      latch_r  <= 1'b0;
    end else if (clk_en) begin
      latch_r <= stb_sy_r[1] && !stb_prev_r;
      if (stb_sy_r[1] && !stb_prev_r) begin
        // R23: select sampled at strobe
        word_r   <= shift_r;
        select_r <= dat_sy_r[1];
      end
    end
  end
endmodule : serial_port_rx

/* File: verilog/motor_serial_setup_port.sv */
/*
 * two independent serial setup ports for a four-bridge motor driver.
 * port one holds setup and extended setup (written in sleep) and the
 * first-pair stepper word; port two holds the second-pair stepper word.
 * assumes pins are asynchronous; protection flags are live levels from
 * the analog side; identifiers are arbitrary parameters.
 */
`timescale 1ns/1ps

// Functional notes
// R1: sixteen bits shift in on falling clock
// R2: strobe rise latches whole word at once
// R3: strobe level ignored, only rising edge counts
// R4: two independent ports, one per bridge pair
// R5: configuration only via first port in sleep
// R6: host raises sleep input before driving motors
// R7: host sets up after reset output high
// R8: sleep low: outputs off, parameters cleared
// R9: sleep assertion shuts drive down immediately; here drive_enable_r falls three ref_clk cycles later
// R10: data low at strobe selects setup register
// R11: data high at strobe selects extended setup
// R12: extended setup: monitor, ignore faults, suppress reset
// R13: identifiers readable on monitor, four select bits
// R14: bits 2..0 select bridge configuration
// R15: blanking fields per side, eighths of period
// R16: dc blanking at phase change, chop start
// R17: stepper uses fixed blanking, fields ignored
// R18: bits 7..9 switch converters, 1 off
// R19: channel three switch ignored when strap high
// R20: bits 10,11 choose current-sense gain
// R21: bits 13:12 converter oscillator, live change allowed; here the setup word is written only in sleep
// R22: bits 15:14 motor oscillator frequency
// R23: select sampled at strobe, first bit msb
module motor_serial_setup_port
  import motor_setup_pkg::*;
#(
  parameter logic [2:0] DEVICE_ID = 3'h5,  // arbitrary value
  parameter logic       VENDOR_ID = 1'b1   // arbitrary value
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic                  serial_clock_first_pair,
  input  wire logic                  serial_data_first_pair,
  input  wire logic                  latch_strobe_first_pair,
  input  wire logic                  serial_clock_second_pair,
  input  wire logic                  serial_data_second_pair,
  input  wire logic                  latch_strobe_second_pair,
  input  wire logic                  sleep_setup_select_n,
  input  wire logic                  converter_mode_strap,
  input  wire logic [3:0]            fault_in,
  input  wire logic                  chop_start,
  input  wire logic                  phase_change,
  output logic [15:0]                motor_setup_config,
  output logic [15:0]                ext_setup_r,
  output motor_setup_pkg::bridge_cfg_e bridge_cfg_r,
  output logic [1:0]                 blanking_time_field_ab_r,
  output logic [1:0]                 blanking_time_field_cd_r,
  output logic [3:0]                 blank_eighths_ab_r,
  output logic [3:0]                 blank_eighths_cd_r,
  output logic                       blank_start_r,
  output logic                       converter_channel_first_r,
  output logic                       converter_channel_second_r,
  output logic                       converter_channel_third_r,
  output logic                       gain_ab_r,
  output logic                       gain_cd_r,
  output logic [1:0]                 converter_oscillator_field_r,
  output logic [1:0]                 motor_oscillator_field_r,
  output logic [15:0]                step_param_ab_r,
  output logic [15:0]                step_param_cd_r,
  output logic                       drive_enable_r,
  output logic                       monitor_out_r,
  output logic [3:0]                 shutdown_r,
  output logic                       reset_output_n
);
  import motor_setup_pkg::*;

  logic [WORD_W-1:0] word_ab;
  logic [WORD_W-1:0] word_cd;
  logic              sel_ab;
  logic              sel_cd;
  logic              latch_ab;
  logic              latch_cd;
  logic [1:0]        sleep_sy_r;
  logic [1:0]        strap_sy_r;
  logic [3:0]        fault_sy1_r;
  logic [3:0]        fault_sy2_r;
  logic [1:0]        edge_sy1_r;
  logic [1:0]        edge_sy2_r;
  logic [1:0]        edge_prev_r;
  logic [3:0]        fault_latch_r;
  logic              sleep_n;
  logic              strap;
  logic              dc_ab;
  logic              dc_cd;

  // R4: separate receivers per pair
  serial_port_rx #(.W(WORD_W)) u_rx_ab (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .ser_clk  (serial_clock_first_pair),
    .ser_data (serial_data_first_pair),
    .strobe   (latch_strobe_first_pair),
    .word_r   (word_ab),
    .select_r (sel_ab),
    .latch_r  (latch_ab)
  );

  serial_port_rx #(.W(WORD_W)) u_rx_cd (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .ser_clk  (serial_clock_second_pair),
    .ser_data (serial_data_second_pair),
    .strobe   (latch_strobe_second_pair),
    .word_r   (word_cd),
    .select_r (sel_cd),
    .latch_r  (latch_cd)
  );

  // two-flop synchronisers for every pin input
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_sy_r  <= 2'h0;
      strap_sy_r  <= 2'h3;
      fault_sy1_r <= 4'h0;
      fault_sy2_r <= 4'h0;
      edge_sy1_r  <= 2'h0;
      edge_sy2_r  <= 2'h0;
      edge_prev_r <= 2'h0;
    end else if (clk_en) begin
      sleep_sy_r  <= {sleep_sy_r[0], sleep_setup_select_n};
      strap_sy_r  <= {strap_sy_r[0], converter_mode_strap};
      fault_sy1_r <= fault_in;
      fault_sy2_r <= fault_sy1_r;
      edge_sy1_r  <= {phase_change, chop_start};
      edge_sy2_r  <= edge_sy1_r;
      edge_prev_r <= edge_sy2_r;
    end
  end

  // only the second flops are read by logic
  assign sleep_n = sleep_sy_r[1];
  assign strap   = strap_sy_r[1];

  // setup and extended setup, first port only, in sleep
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_setup_config <= SETUP_RESET;
      ext_setup_r        <= EXT_RESET;
    end else if (clk_en && latch_ab && !sleep_n) begin
      // R5: only first port in sleep
      if (!sel_ab) begin
        // R10: data low selects setup
        motor_setup_config <= word_ab;
      end else begin
        // R11: data high selects extended
        ext_setup_r <= word_ab;
      end
    end
  end

  // stepper parameter words, one per pair
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_param_ab_r <= PARAM_RESET;
      step_param_cd_r <= PARAM_RESET;
    end else if (clk_en) begin
      if (!sleep_n) begin
        // R8: parameters cleared in sleep
        step_param_ab_r <= PARAM_RESET;
        step_param_cd_r <= PARAM_RESET;
      end else begin
        // R2: whole word latched at once
        if (latch_ab) begin
          step_param_ab_r <= word_ab;
        end
        if (latch_cd) begin
          step_param_cd_r <= word_cd;
        end
      end
    end
  end

  // R9: drive enable follows sleep
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_enable_r <= 1'b0;
    end else if (clk_en) begin
      drive_enable_r <= sleep_n;
    end
  end

  // decoded setup fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bridge_cfg_r                 <= CFG_DUAL_STEPPER;
      blanking_time_field_ab_r     <= 2'h0;
      blanking_time_field_cd_r     <= 2'h0;
      converter_channel_first_r    <= 1'b1;
      converter_channel_second_r   <= 1'b1;
      converter_channel_third_r    <= 1'b1;
      gain_ab_r                    <= 1'b0;
      gain_cd_r                    <= 1'b0;
      converter_oscillator_field_r <= 2'h0;
      motor_oscillator_field_r     <= 2'h0;
    end else if (clk_en) begin
      // R14: bridge configuration
      bridge_cfg_r <= bridge_cfg_e'(motor_setup_config[CFG_LSB +: 3]);
      // R15: per-side blanking fields
      blanking_time_field_ab_r <= motor_setup_config[BLANK_AB_LSB +: 2];
      blanking_time_field_cd_r <= motor_setup_config[BLANK_CD_LSB +: 2];
      // R18: 0 keeps channel on
      converter_channel_first_r  <= !motor_setup_config[CONV_A_BIT];
      converter_channel_second_r <= !motor_setup_config[CONV_B_BIT];
      // R19: strap high forces channel on
      converter_channel_third_r  <= strap || !motor_setup_config[CONV_C_BIT];
      // R20: sense gain selects
      gain_ab_r <= motor_setup_config[GAIN_AB_BIT];
      gain_cd_r <= motor_setup_config[GAIN_CD_BIT];
      // R21: converter oscillator, live
      converter_oscillator_field_r <= motor_setup_config[CONV_OSC_LSB +: 2];
      // R22: motor oscillator select
      motor_oscillator_field_r <= motor_setup_config[MOT_OSC_LSB +: 2];
    end
  end

  // field code to eighths of the chopping period
  function automatic logic [3:0] blank_eighths(input logic [1:0] f);
    case (f)
      2'h0:    blank_eighths = 4'h5;
      2'h1:    blank_eighths = 4'h6;
      2'h2:    blank_eighths = 4'h3;
      default: blank_eighths = 4'h4;
    endcase
  endfunction : blank_eighths

  // dc pairs per configuration (ab uses dc in modes 3,4,5,7)
  always_comb begin
    case (bridge_cfg_r)
      CFG_LARGE_DC_TWO_SMALL_DC, CFG_TWO_LARGE_DC, CFG_FOUR_SMALL_DC,
      CFG_ULTRA_LARGE_DC: dc_ab = 1'b1;
      default:            dc_ab = 1'b0;
    endcase
    case (bridge_cfg_r)
      CFG_DUAL_STEPPER, CFG_LARGE_STEPPER: dc_cd = 1'b0;
      default:                             dc_cd = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_eighths_ab_r <= STEP_BLANK_EIGHTHS;
      blank_eighths_cd_r <= STEP_BLANK_EIGHTHS;
      blank_start_r      <= 1'b0;
    end else if (clk_en) begin
      // R17: stepper fixed blanking
      blank_eighths_ab_r <= dc_ab ? blank_eighths(blanking_time_field_ab_r)
                                  : STEP_BLANK_EIGHTHS;
      blank_eighths_cd_r <= dc_cd ? blank_eighths(blanking_time_field_cd_r)
                                  : STEP_BLANK_EIGHTHS;
      // R16: blank at phase or chop
      blank_start_r <= (dc_ab || dc_cd) && |(edge_sy2_r & ~edge_prev_r);
    end
  end

  // R12: latched faults, ignore masks, reset suppress
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_latch_r <= 4'h0;
      shutdown_r    <= 4'h0;
    end else if (clk_en) begin
      if (!sleep_n) begin
        // live faults still set while sleep clears the latch
        fault_latch_r <= fault_sy2_r;
      end else begin
        fault_latch_r <= fault_latch_r | fault_sy2_r;
      end
      shutdown_r <= fault_latch_r & ~ext_setup_r[IGNORE_LSB +: 4];
    end
  end

  // R12: suppress bit holds reset output high
  assign reset_output_n = !(|shutdown_r) || ext_setup_r[ORT_SUPPR_BIT];

  // R13: monitor selector with identifiers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_out_r <= 1'b0;
    end else if (clk_en) begin
      case (ext_setup_r[MON_SEL_LSB +: 4])
        4'h1:        monitor_out_r <= fault_latch_r[0];
        4'h2:        monitor_out_r <= fault_latch_r[1];
        4'h3:        monitor_out_r <= fault_latch_r[2];
        4'h4:        monitor_out_r <= fault_latch_r[3];
        MON_DEV_ID0: monitor_out_r <= DEVICE_ID[0];
        MON_DEV_ID1: monitor_out_r <= DEVICE_ID[1];
        MON_DEV_ID2: monitor_out_r <= DEVICE_ID[2];
        MON_VEND_ID: monitor_out_r <= VENDOR_ID;
        default:     monitor_out_r <= 1'b0;
      endcase
    end
  end
endmodule : motor_serial_setup_port

/* File: test/motor_host_model.sv */
/*
 * host side of one three-wire setup port: shifts a word msb first and
 * strobes it in, with a chosen data level at the strobe rise.
 * assumes ref_clk is the bench clock; serial clock runs at 320 ns.
 */
`timescale 1ns/1ps
module motor_host_model (
  input  wire logic ref_clk,
  input  wire logic reset_output_n,
  output logic      sclk,
  output logic      sdata,
  output logic      strobe
);
  initial begin
    sclk   = 1'b1;
    sdata  = 1'b0;
    strobe = 1'b0;
  end

  task automatic send(input logic [15:0] word, input logic sel, input logic hold_hi);
    int i;
    while (reset_output_n !== 1'b1) @(posedge ref_clk);
    // a held strobe stays high from the last latch; a rise here would latch
    if (!hold_hi)
      strobe <= 1'b0;
    // first bit lands in bit 15
    for (i = 15; i >= 0; i--) begin
      sdata <= word[i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
    end
    sdata  <= sel;
    strobe <= 1'b0;
    repeat (4) @(posedge ref_clk);
    strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sdata  <= ~sel;
    repeat (8) @(posedge ref_clk);
  endtask : send
endmodule : motor_host_model

/* File: test/motor_serial_setup_port_asserts.sv */
/*
 * concurrent checks on the setup port's top-level ports.
 * assumes the design package is compiled first; attached by bind below.
 */
`timescale 1ns/1ps
module motor_setup_port_asserts
  import motor_setup_pkg::*;
(
  input wire logic                          ref_clk,
  input wire logic                          rst_n,
  input wire logic                          sleep_setup_select_n,
  input wire logic                          chop_start,
  input wire logic                          phase_change,
  input wire logic [15:0]                   motor_setup_config,
  input wire logic [15:0]                   ext_setup_r,
  input wire motor_setup_pkg::bridge_cfg_e  bridge_cfg_r,
  input wire logic                          blank_start_r,
  input wire logic                          converter_channel_first_r,
  input wire logic                          converter_channel_second_r,
  input wire logic                          gain_ab_r,
  input wire logic                          gain_cd_r,
  input wire logic [1:0]                    converter_oscillator_field_r,
  input wire logic [1:0]                    motor_oscillator_field_r,
  input wire logic [15:0]                   step_param_ab_r,
  input wire logic [15:0]                   step_param_cd_r,
  input wire logic                          drive_enable_r
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence setup_written;
    $changed(motor_setup_config);
  endsequence
  sequence edge_seen;
    $rose(chop_start) || $rose(phase_change);
  endsequence

  chk_setup_in_sleep: assert property (setup_written |-> !$past(drive_enable_r))
    else $error("setup register changed outside sleep");
  chk_ext_in_sleep: assert property ($changed(ext_setup_r) |-> !$past(drive_enable_r))
    else $error("extended setup changed outside sleep");
  chk_params_cleared: assert property (!drive_enable_r && !$past(drive_enable_r)
    |-> step_param_ab_r == 16'h0000 && step_param_cd_r == 16'h0000)
    else $error("stepper words not cleared in sleep");
  chk_sleep_stops_drive: assert property (!sleep_setup_select_n [*4] |-> !drive_enable_r)
    else $error("drive still enabled in sleep");
  chk_cfg_decode: assert property (setup_written |=> bridge_cfg_r == $past(motor_setup_config[2:0]))
    else $error("bridge configuration not decoded");
  chk_osc_decode: assert property (setup_written |=>
    {motor_oscillator_field_r, converter_oscillator_field_r} == $past(motor_setup_config[15:12]))
    else $error("oscillator fields not decoded");
  chk_gain_decode: assert property (setup_written |=>
    {gain_cd_r, gain_ab_r} == $past(motor_setup_config[11:10]))
    else $error("gain bits not decoded");
  chk_conv_decode: assert property (setup_written |=>
    {converter_channel_second_r, converter_channel_first_r} == ~$past(motor_setup_config[8:7]))
    else $error("converter switches not decoded");
  chk_blank_start: assert property (drive_enable_r && bridge_cfg_r == CFG_ULTRA_LARGE_DC
    ##0 edge_seen |-> ##[1:5] blank_start_r)
    else $error("no blanking start after chop or phase edge");
  chk_blank_pulse: assert property (blank_start_r |=> !blank_start_r)
    else $error("blanking start longer than one cycle");
endmodule : motor_setup_port_asserts

bind motor_serial_setup_port motor_setup_port_asserts chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .sleep_setup_select_n(sleep_setup_select_n),
  .chop_start(chop_start), .phase_change(phase_change),
  .motor_setup_config(motor_setup_config), .ext_setup_r(ext_setup_r),
  .bridge_cfg_r(bridge_cfg_r), .blank_start_r(blank_start_r),
  .converter_channel_first_r(converter_channel_first_r),
  .converter_channel_second_r(converter_channel_second_r),
  .gain_ab_r(gain_ab_r), .gain_cd_r(gain_cd_r),
  .converter_oscillator_field_r(converter_oscillator_field_r),
  .motor_oscillator_field_r(motor_oscillator_field_r),
  .step_param_ab_r(step_param_ab_r), .step_param_cd_r(step_param_cd_r),
  .drive_enable_r(drive_enable_r)
);

/* File: test/motor_serial_setup_port_bench.sv */
/*
 * bench for the motor serial setup port: two host models, sleep and strap.
 * assumes the package, design, checker and host model are compiled first.
 */
`timescale 1ns/1ps
module motor_serial_setup_port_bench;
  import motor_setup_pkg::*;
  localparam logic [2:0] DEV = 3'h6;  // arbitrary value
  localparam logic       VEN = 1'b0;  // arbitrary value
  logic        ref_clk, rst_n, clk_en, sleep_setup_select_n, converter_mode_strap;
  logic        chop_start, phase_change;
  logic [3:0]  fault_in;
  wire logic   serial_clock_first_pair, serial_data_first_pair, latch_strobe_first_pair;
  wire logic   serial_clock_second_pair, serial_data_second_pair, latch_strobe_second_pair;
  wire logic [15:0] motor_setup_config, ext_setup_r, step_param_ab_r, step_param_cd_r;
  wire bridge_cfg_e bridge_cfg_r;
  wire logic [3:0]  blank_eighths_ab_r, blank_eighths_cd_r;
  wire logic [1:0]  converter_oscillator_field_r, motor_oscillator_field_r;
  wire logic   blank_start_r, converter_channel_first_r, converter_channel_second_r;
  wire logic   converter_channel_third_r, gain_ab_r, gain_cd_r, drive_enable_r;
  wire logic   monitor_out_r, reset_output_n;
  int          n_mismatch, num_checks, i, n_blank;
  logic [2:0]  c;
  logic [15:0] w;

  motor_serial_setup_port #(.DEVICE_ID(DEV), .VENDOR_ID(VEN)) dut_u (
    .ref_clk, .rst_n, .clk_en, .serial_clock_first_pair, .serial_data_first_pair,
    .latch_strobe_first_pair, .serial_clock_second_pair, .serial_data_second_pair,
    .latch_strobe_second_pair, .sleep_setup_select_n, .converter_mode_strap, .fault_in,
    .chop_start, .phase_change, .motor_setup_config, .ext_setup_r, .bridge_cfg_r,
    .blanking_time_field_ab_r(), .blanking_time_field_cd_r(), .blank_eighths_ab_r,
    .blank_eighths_cd_r, .blank_start_r, .converter_channel_first_r,
    .converter_channel_second_r, .converter_channel_third_r, .gain_ab_r, .gain_cd_r,
    .converter_oscillator_field_r, .motor_oscillator_field_r, .step_param_ab_r,
    .step_param_cd_r, .drive_enable_r, .monitor_out_r, .shutdown_r(), .reset_output_n);
  motor_host_model host_ab (.ref_clk, .reset_output_n, .sclk(serial_clock_first_pair),
    .sdata(serial_data_first_pair), .strobe(latch_strobe_first_pair));
  motor_host_model host_cd (.ref_clk, .reset_output_n, .sclk(serial_clock_second_pair),
    .sdata(serial_data_second_pair), .strobe(latch_strobe_second_pair));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // counts one-cycle blanking starts as they stand
  always @(posedge ref_clk) begin
    if (blank_start_r === 1'b1)
      n_blank++;
  end

  function automatic logic [3:0] eig(input logic [1:0] f);
    return (f == 2'h0) ? 4'h5 : (f == 2'h1) ? 4'h6 : (f == 2'h2) ? 4'h3 : 4'h4;
  endfunction : eig

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic pulse(input logic on_phase);
    if (on_phase)
      phase_change <= 1'b1;
    else
      chop_start <= 1'b1;
    repeat (4) @(posedge ref_clk);
    phase_change <= 1'b0;
    chop_start   <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : pulse

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    repeat (50000) @(posedge ref_clk);
    n_mismatch++;
    $display("ERROR watchdog expected done seen timeout");
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    sleep_setup_select_n = 1'b0;
    converter_mode_strap = 1'b0;
    chop_start = 1'b0;
    phase_change = 1'b0;
    fault_in = 4'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("setup", SETUP_RESET, motor_setup_config);
    chk("conv", 16'h0007, {converter_channel_third_r, converter_channel_second_r,
      converter_channel_first_r});
    // identifier readout through the monitor selector
    for (i = 0; i < 4; i++) begin
      w = {12'h000, MON_DEV_ID0 + 4'(i)};
      host_ab.send(w, 1'b1, 1'b0);
      chk("ext", w, ext_setup_r);
      chk("setup", SETUP_RESET, motor_setup_config);
      chk("monitor", 16'({VEN, DEV} >> i) & 16'h0001, monitor_out_r);
    end
    converter_mode_strap <= 1'b1;
    host_ab.send(16'h0200, 1'b0, 1'b0);
    chk("conv_c", 16'h0001, converter_channel_third_r);
    converter_mode_strap <= 1'b0;
    // every bridge configuration once, each field code in two of them
    for (i = 0; i < 8; i++) begin
      c = 3'(i);
      w = {~c[1:0], c[1:0], ~c[0], c[0], c, ~c[1:0], c[1:0], c};
      host_ab.send(w, 1'b0, c[0]);
      chk("setup", w, motor_setup_config);
      chk("bridge", 16'(c), bridge_cfg_r);
      chk("blank_ab", (c < 3 || c == 6) ? 4'h5 : eig(c[1:0]), blank_eighths_ab_r);
      chk("blank_cd", (c == 0 || c == 6) ? 4'h5 : eig(~c[1:0]), blank_eighths_cd_r);
      chk("conv", {13'h0000, ~c}, {converter_channel_third_r, converter_channel_second_r,
        converter_channel_first_r});
      chk("gain", 16'({~c[0], c[0]}), {gain_cd_r, gain_ab_r});
      chk("osc", 16'(w[15:12]), {motor_oscillator_field_r, converter_oscillator_field_r});
    end
    host_cd.send(16'h1234, 1'b0, 1'b0);
    chk("setup", w, motor_setup_config);
    chk("step_cd", PARAM_RESET, step_param_cd_r);
    sleep_setup_select_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("drive", 16'h0001, drive_enable_r);
    host_ab.send(16'hA5C3, 1'b0, 1'b0);
    chk("step_ab", 16'hA5C3, step_param_ab_r);
    chk("setup", w, motor_setup_config);
    host_cd.send(16'h3C5A, 1'b0, 1'b0);
    chk("step_cd", 16'h3C5A, step_param_cd_r);
    chk("setup", w, motor_setup_config);
    pulse(1'b0);
    pulse(1'b1);
    chk("blank_starts", 16'h0002, 16'(n_blank));
    fault_in <= 4'h4;
    repeat (8) @(posedge ref_clk);
    fault_in <= 4'h0;
    chk("reset_out", 16'h0000, reset_output_n);
    repeat (8) @(posedge ref_clk);
    chk("reset_out", 16'h0000, reset_output_n);
    sleep_setup_select_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("drive", 16'h0000, drive_enable_r);
    chk("reset_out", 16'h0001, reset_output_n);
    chk("step_ab", PARAM_RESET, step_param_ab_r);
    chk("step_cd", PARAM_RESET, step_param_cd_r);
    finish_test();
  end
endmodule : motor_serial_setup_port_bench
